/* dv/lpm_cpu_model.sv */
// Model of the CPU core, interrupt sources and wake pins.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module lpm_cpu_model (
    input  wire logic clk_i,     // Core clock
    output logic      halt_o,    // Halt instruction pulse
    output logic      stby_o,    // Standby instruction pulse
    output logic      pend_o,    // Unmasked interrupt pending
    output logic      ie_o,      // Global interrupt enable
    output logic      tmr_o,     // Timer A overflow
    output logic      ext_interrupt_zero_n_o,  // External int 0 pin
    output logic      stop_cancel_pin_n_o  // Stop-cancel pin
);
    //----------------------------------------------------------------
    // Idle levels: wake pins have pull-ups, so they rest high
    //----------------------------------------------------------------
    initial begin
        halt_o    = 1'b0;
        stby_o    = 1'b0;
        pend_o    = 1'b0;
        ie_o      = 1'b0;
        tmr_o     = 1'b0;
        ext_interrupt_zero_n_o  = 1'b1;
        stop_cancel_pin_n_o = 1'b1;
    end
    // One-cycle instruction strobe, launched just after an edge
    task automatic instr(input logic is_halt);
        @(posedge clk_i);
        halt_o <= is_halt;
        stby_o <= !is_halt;
        @(posedge clk_i);
        halt_o <= 1'b0;
        stby_o <= 1'b0;
    endtask : instr
    // Levels {pend, ie, tmr, ext_interrupt_zero_n, stop_cancel_pin_n}; the caller keeps each
    // level until its next call, sometimes for less than a frame
    task automatic pins(input logic [4:0] v);
        @(posedge clk_i);
        pend_o    <= v[4];
        ie_o      <= v[3];
        tmr_o     <= v[2];
        ext_interrupt_zero_n_o  <= v[1];
        stop_cancel_pin_n_o <= v[0];
    endtask : pins
endmodule : lpm_cpu_model

/* dv/tb_lpm_ctrl.sv */
// Self-checking bench for the low-power mode controller.
// Assumes the settle count is shortened to 20 cycles.
`timescale 1ns/1ps
module tb_lpm_ctrl;
    import lpm_pkg::*;
    localparam int SETTLE = 20;  // Short settle count for simulation
    logic clk, nrst, psel, penable, pwrite, sr, ss, err;
    logic [7:0]  paddr;          // APB byte address
    logic [31:0] pwdata, rdat;   // APB data
    logic [31:0] prdata;
    logic pready, pslverr, halt, stby, pend, ie, tmr, i0n, scn;
    logic restart, resume, i0req, strobe, ram;
    int n_strb = 0;              // Strobe pulses seen
    int n_i0 = 0;                // Int 0 request pulses seen
    lpm_mode_t  mode;
    lpm_ctl_t   ctl;
    int n_mismatch = 0;
    int check_count = 0;
    int n;
    lpm_ctrl #(.SETTLE_CYCLES(SETTLE)) i_dut (.CORE_CLK_I(clk),
        .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .HALT_INSTR_I(halt), .STANDBY_INSTR_I(stby), .INT_PEND_I(pend),
        .GLOBAL_IE_I(ie), .TMR_A_IRQ_I(tmr), .EXT_EXT_INTERRUPT_ZERO_N_I(i0n),
        .STOP_CANCEL_N_I(scn), .MODE_O(mode), .CTL_O(ctl),
        .RESTART_O(restart), .RESUME_O(resume), .EXT_INTERRUPT_ZERO_REQ_O(i0req),
        .STROBE_O(strobe), .RAM_EN_FLAG_O(ram));
    lpm_cpu_model i_cpu (.clk_i(clk), .halt_o(halt), .stby_o(stby),
        .pend_o(pend), .ie_o(ie), .tmr_o(tmr), .ext_interrupt_zero_n_o(i0n),
        .stop_cancel_pin_n_o(scn));
    //----------------------------------------------------------------
    // Clock, verdict and compare tasks
    //----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Pulse counters sample on the falling edge, where outputs are settled
    always @(negedge clk) begin
        if (strobe === 1'b1) n_strb++;
        if (i0req === 1'b1) n_i0++;
    end
    task automatic report_and_stop;
        $display("Mismatches %0d of %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32
    // Waits for a mode under a bound; a run-out ends the test
    task automatic to_mode(input lpm_mode_t exp, input int bound);
        n = 0;
        #1;
        while (mode !== exp && n < bound) begin
            @(posedge clk);
            #1;
            n++;
        end
        {sr, ss} = {resume, restart};
        chk32({29'h0, mode}, {29'h0, exp});
        if (mode !== exp) report_and_stop();
    endtask : to_mode
    // APB transfer: setup, then access held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        {rdat, err} = {prdata, pslverr};
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk32(rdat, e);
    endtask : rd
    //----------------------------------------------------------------
    // Scenarios
    //----------------------------------------------------------------
    initial begin
        nrst    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        i_cpu.pins(5'h0b);                      // Ie set, pins idle
        to_mode(LPM_ACTIVE, 1);
        rd(LPM_STAT_OFS, 32'h0);
        rd(LPM_FRAME_OFS, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk32({31'h0, err}, 32'h1);             // Unmapped is refused
        // Frame select 1: two strobes in two long frames, then back
        apb(1'b1, LPM_FRAME_OFS, 32'h1);
        rd(LPM_FRAME_OFS, 32'h1);
        repeat (FRAME1_CYC + 2) @(posedge clk);
        n = n_strb;
        repeat (2 * FRAME1_CYC) @(posedge clk);
        chk32(n_strb - n, 32'h2);
        apb(1'b1, LPM_FRAME_OFS, 32'h0);
        // Standby, then wake by a pending interrupt
        i_cpu.instr(1'b0);
        to_mode(LPM_STANDBY, 1);
        chk32({30'h0, ctl.sys_osc_en, ctl.cpu_clk_en}, 32'h2);
        i_cpu.pins(5'h1b);
        to_mode(LPM_ACTIVE, 4);
        chk32({31'h0, sr}, 32'h1);
        // Pending interrupt with ie clear turns halt into a no-op
        i_cpu.pins(5'h13);
        i_cpu.instr(1'b1);
        to_mode(LPM_ACTIVE, 1);
        // Stop-cancel outside stop is ignored, then stop and cancel
        i_cpu.pins(5'h0a);
        repeat (8) @(posedge clk);
        i_cpu.pins(5'h0b);
        to_mode(LPM_ACTIVE, 1);
        chk32({31'h0, ram}, 32'h0);
        i_cpu.instr(1'b1);
        to_mode(LPM_STOP, 1);
        chk32({30'h0, ctl.sys_osc_en, ctl.port_hiz}, 32'h1);
        i_cpu.pins(5'h0a);
        to_mode(LPM_ACTIVE, SETTLE + 8);
        chk32({31'h0, ss}, 32'h1);
        i_cpu.pins(5'h0b);
        rd(LPM_STAT_OFS, 32'h10);
        // Watch, timer wake into subactive, back to watch, again up
        apb(1'b1, LPM_CTRL_OFS, 32'h9);
        i_cpu.instr(1'b1);
        to_mode(LPM_WATCH, 1);
        chk32({31'h0, ctl.tmr_a_only}, 32'h1);
        i_cpu.pins(5'h0f);
        to_mode(LPM_SUBACT, 80);
        i_cpu.pins(5'h0b);
        chk32({30'h0, ctl.sys_osc_en, ctl.adc_en}, 32'h0);
        i_cpu.instr(1'b0);
        to_mode(LPM_WATCH, 1);
        i_cpu.pins(5'h0f);
        to_mode(LPM_SUBACT, 80);
        i_cpu.pins(5'h0b);
        // Direct transfer from subactive to active
        apb(1'b1, LPM_CTRL_OFS, 32'h11);
        rd(LPM_CTRL_OFS, 32'h11);
        i_cpu.instr(1'b1);
        to_mode(LPM_SETTLE, 1);
        to_mode(LPM_ACTIVE, SETTLE + 2);
        rd(LPM_CTRL_OFS, 32'h1);
        // Ext_interrupt_zero falling edge wakes watch into active mode
        i_cpu.instr(1'b1);
        to_mode(LPM_WATCH, 1);
        i_cpu.pins(5'h09);
        to_mode(LPM_ACTIVE, 2 * 64 + SETTLE + 8);
        chk32({31'h0, n > FRAME0_CYC + SETTLE}, 32'h1);
        chk32({30'h0, ss, sr}, 32'h1);
        chk32(n_i0, 32'h1);
        repeat (70) @(posedge clk);
        i_cpu.pins(5'h0b);
        // Reset in mid-run from watch lands in active, RAM flag clear
        i_cpu.instr(1'b1);
        to_mode(LPM_WATCH, 1);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        to_mode(LPM_ACTIVE, 1);
        chk32({31'h0, ram}, 32'h0);
        rd(LPM_CTRL_OFS, 32'h0);
        report_and_stop();
    end
endmodule : tb_lpm_ctrl

/* src/lpm_ctrl.sv */
// Low-power operating-mode sequencer with an APB register port.
// Assumes the CPU pulses the halt and standby strobes for one cycle and
// that wake pins are asynchronous to CORE_CLK_I.
`timescale 1ns/1ps
module lpm_ctrl #(
    parameter int SETTLE_CYCLES = lpm_pkg::SETTLE_CYC // Osc settle count
)(
    input  wire logic        CORE_CLK_I,     // Core clock
    input  wire logic        NRST_I,         // Async reset, low
    input  wire logic        PSEL_I,         // APB select
    input  wire logic        PENABLE_I,      // APB enable
    input  wire logic        PWRITE_I,       // APB direction
    input  wire logic [7:0]  PADDR_I,        // APB byte address
    input  wire logic [31:0] PWDATA_I,       // APB write data
    output logic      [31:0] PRDATA_O,       // APB read data
    output logic             PREADY_O,       // APB ready
    output logic             PSLVERR_O,      // APB error
    input  wire logic        HALT_INSTR_I,   // Halt instruction pulse
    input  wire logic        STANDBY_INSTR_I,// Standby instruction pulse
    input  wire logic        INT_PEND_I,     // Unmasked interrupt pending
    input  wire logic        GLOBAL_IE_I,    // Global interrupt enable
    input  wire logic        TMR_A_IRQ_I,    // Timer A overflow
    input  wire logic        EXT_EXT_INTERRUPT_ZERO_N_I,   // External int 0 pin, low
    input  wire logic        STOP_CANCEL_N_I,// Stop-cancel pin, low
    output lpm_pkg::lpm_mode_t MODE_O,       // Current mode
    output lpm_pkg::lpm_ctl_t  CTL_O,        // Clock and reset controls
    output logic             RESTART_O,      // Restart at address 0
    output logic             RESUME_O,       // Resume next instruction
    output logic             EXT_INTERRUPT_ZERO_REQ_O,     // Int 0 request
    output logic             STROBE_O,       // Interrupt strobe
    output logic             RAM_EN_FLAG_O   // RAM enable flag
);
    import lpm_pkg::*;

    //----------------------------------------------------------------
    // Pin synchronisers
    //----------------------------------------------------------------
    logic [1:0] ext_interrupt_zero_sync_ff;     // Int 0 pin stages
    logic [1:0] stop_cancel_pin_sync_ff;    // Stop-cancel stages

    // Two stages; only bit 1 is read by logic
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ext_interrupt_zero_sync_ff  <= 2'h3;
            stop_cancel_pin_sync_ff <= 2'h3;
        end else begin
            ext_interrupt_zero_sync_ff  <= {ext_interrupt_zero_sync_ff[0], EXT_EXT_INTERRUPT_ZERO_N_I};
            stop_cancel_pin_sync_ff <= {stop_cancel_pin_sync_ff[0], STOP_CANCEL_N_I};
        end
    end

    wire logic ext_interrupt_zero_lvl  = ext_interrupt_zero_sync_ff[1];   // Synchronised int 0
    wire logic stop_cancel_pin_act = ~stop_cancel_pin_sync_ff[1]; // Stop-cancel active

    //----------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------
    logic [4:0]  ctrl_ff;         // Control bits
    logic [1:0]  frame_sel_ff;    // Frame length select
    lpm_mode_t   mode_ff;         // Current mode
    lpm_mode_t   settle_tgt_ff;   // Mode after settling
    logic [31:0] settle_cnt_ff;   // Settle counter
    logic [8:0]  frame_cnt_ff;    // Frame counter
    logic        strobe_ff;       // Strobe pulse
    logic        ext_interrupt_zero_smp_ff;     // Last frame sample
    logic        ext_interrupt_zero_edge_ff;    // Edge waiting for second strobe
    logic        ext_interrupt_zero_req_ff;     // Int 0 request
    logic        ram_en_ff;       // RAM enable flag
    logic        restart_ff;      // Restart pulse
    logic        resume_ff;       // Resume pulse
    logic        was_stop_ff;     // Settling came from stop
    logic [31:0] prdata_ff;       // Read data

    wire logic apb_acc = PSEL_I & PENABLE_I;
    wire logic apb_wr  = apb_acc & PWRITE_I;
    wire logic apb_rd  = apb_acc & ~PWRITE_I;

    // Address decode shared by read and write
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == LPM_CTRL_OFS) || (a == LPM_STAT_OFS) ||
                  (a == LPM_FRAME_OFS);
    endfunction : addr_ok

    // Frame length lookup
    function automatic logic [8:0] frame_len(input logic [1:0] s);
        case (s)
            2'h0:    frame_len = 9'(FRAME0_CYC);
            2'h1:    frame_len = 9'(FRAME1_CYC);
            default: frame_len = 9'(FRAME2_CYC);
        endcase
    endfunction : frame_len

    assign PREADY_O  = 1'b1;               // Zero wait states
    assign PSLVERR_O = apb_acc & ~addr_ok(PADDR_I);
    assign PRDATA_O  = prdata_ff;

    // Control register; the direct flag only sticks in subactive
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_ff <= CTRL_RST;
        end else begin
            if (apb_wr && PADDR_I == LPM_CTRL_OFS) begin
                ctrl_ff <= PWDATA_I[4:0];
                if (mode_ff != LPM_SUBACT) begin
                    ctrl_ff[CTRL_DIRECT] <= 1'b0;
                end
            end else if (mode_ff == LPM_ACTIVE) begin
                ctrl_ff[CTRL_DIRECT] <= 1'b0;
            end
            if (mode_ff == LPM_STOP) begin
                // Speed bit clears in stop; stop bit changes only by reset or a write
                ctrl_ff[CTRL_SUB_SPEED] <= 1'b0;
            end
        end
    end

    // Frame select register
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            frame_sel_ff <= FRAME_RST;
        end else if (apb_wr && PADDR_I == LPM_FRAME_OFS) begin
            frame_sel_ff <= PWDATA_I[1:0];
        end
    end

    // Read data; unmapped reads return zero
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            prdata_ff <= 32'h0;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            case (PADDR_I)
                LPM_CTRL_OFS:  prdata_ff <= {27'h0, ctrl_ff};
                LPM_STAT_OFS:  prdata_ff <= {27'h0, ram_en_ff, ext_interrupt_zero_req_ff,
                                             mode_ff};
                LPM_FRAME_OFS: prdata_ff <= {30'h0, frame_sel_ff};
                default:       prdata_ff <= 32'h0;
            endcase
        end
    end

    //----------------------------------------------------------------
    // Interrupt frame and int 0 edge
    //----------------------------------------------------------------
    wire logic low_pwr = (mode_ff == LPM_WATCH) || (mode_ff == LPM_SUBACT);

    // Frame counter makes one strobe per frame
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            frame_cnt_ff <= 9'h0;
            strobe_ff    <= 1'b0;
        end else if (frame_cnt_ff >= frame_len(frame_sel_ff) - 9'h1) begin
            frame_cnt_ff <= 9'h0;
            strobe_ff    <= 1'b1;
        end else begin
            frame_cnt_ff <= frame_cnt_ff + 9'h1;
            strobe_ff    <= 1'b0;
        end
    end

    // Sample per frame; edge waits for the second strobe in low power.
    // Short pulses between samples are missed by design.
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ext_interrupt_zero_smp_ff  <= 1'b1;
            ext_interrupt_zero_edge_ff <= 1'b0;
            ext_interrupt_zero_req_ff  <= 1'b0;
        end else begin
            ext_interrupt_zero_req_ff <= 1'b0;
            if (strobe_ff) begin
                ext_interrupt_zero_smp_ff <= ext_interrupt_zero_lvl;
                if (ext_interrupt_zero_edge_ff) begin
                    ext_interrupt_zero_edge_ff <= 1'b0;
                    ext_interrupt_zero_req_ff  <= 1'b1;
                end else if (ext_interrupt_zero_smp_ff && !ext_interrupt_zero_lvl) begin
                    if (low_pwr) begin
                        ext_interrupt_zero_edge_ff <= 1'b1;
                    end else begin
                        ext_interrupt_zero_req_ff  <= 1'b1;
                    end
                end
            end
        end
    end

    //----------------------------------------------------------------
    // Mode sequencer
    //----------------------------------------------------------------
    wire logic lp_instr = HALT_INSTR_I | STANDBY_INSTR_I;
    wire logic nop_inh  = INT_PEND_I & ~GLOBAL_IE_I;
    wire logic wake_w   = (TMR_A_IRQ_I & strobe_ff) | ext_interrupt_zero_req_ff;

    // Sequencer; reset lands in active from any state
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mode_ff       <= LPM_ACTIVE;
            settle_tgt_ff <= LPM_ACTIVE;
            settle_cnt_ff <= 32'h0;
            restart_ff    <= 1'b0;
            resume_ff     <= 1'b0;
            was_stop_ff   <= 1'b0;
        end else begin
            restart_ff <= 1'b0;
            resume_ff  <= 1'b0;
            case (mode_ff)
                LPM_ACTIVE: begin
                    if (STANDBY_INSTR_I && !nop_inh) begin
                        mode_ff <= LPM_STANDBY;
                    end else if (HALT_INSTR_I && !nop_inh) begin
                        mode_ff <= ctrl_ff[CTRL_WATCH_SEL] ?
                                   LPM_WATCH : LPM_STOP;
                    end
                end
                LPM_STANDBY: begin
                    if (INT_PEND_I) begin
                        mode_ff   <= LPM_ACTIVE;
                        resume_ff <= 1'b1;
                    end
                end
                LPM_STOP: begin
                    if (stop_cancel_pin_act) begin
                        mode_ff       <= LPM_SETTLE;
                        settle_tgt_ff <= LPM_ACTIVE;
                        settle_cnt_ff <= 32'(SETTLE_CYCLES);
                        was_stop_ff   <= 1'b1;
                    end
                end
                LPM_WATCH: begin
                    if (wake_w) begin
                        if (ctrl_ff[CTRL_LOW_SPEED]) begin
                            mode_ff   <= LPM_SUBACT;
                            resume_ff <= 1'b1;
                        end else begin
                            mode_ff       <= LPM_SETTLE;
                            settle_tgt_ff <= LPM_ACTIVE;
                            settle_cnt_ff <= 32'(SETTLE_CYCLES);
                            was_stop_ff   <= 1'b0;
                        end
                    end
                end
                LPM_SUBACT: begin
                    if (lp_instr && !nop_inh) begin
                        if (!ctrl_ff[CTRL_LOW_SPEED] &&
                            ctrl_ff[CTRL_DIRECT]) begin
                            mode_ff       <= LPM_SETTLE;
                            settle_tgt_ff <= LPM_ACTIVE;
                            settle_cnt_ff <= 32'(SETTLE_CYCLES);
                            was_stop_ff   <= 1'b0;
                        end else begin
                            mode_ff <= LPM_WATCH;
                        end
                    end
                end
                LPM_SETTLE: begin
                    if (settle_cnt_ff <= 32'h1) begin
                        mode_ff    <= settle_tgt_ff;
                        restart_ff <= was_stop_ff;
                        resume_ff  <= ~was_stop_ff;
                    end else begin
                        settle_cnt_ff <= settle_cnt_ff - 32'h1;
                    end
                end
                default: mode_ff <= LPM_ACTIVE;
            endcase
        end
    end

    // RAM flag: reset clears, stop-cancel sets
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ram_en_ff <= 1'b0;
        end else if (mode_ff == LPM_STOP && stop_cancel_pin_act) begin
            ram_en_ff <= 1'b1;
        end
    end

    //----------------------------------------------------------------
    // Control outputs
    //----------------------------------------------------------------
    // RAM is never reset here, so it survives stop
    always_comb begin
        CTL_O            = '0;
        CTL_O.sub_osc_en = 1'b1;
        CTL_O.in_en      = (mode_ff == LPM_ACTIVE) ||
                           (mode_ff == LPM_SUBACT);
        case (mode_ff)
            LPM_ACTIVE: begin
                CTL_O.sys_osc_en = 1'b1;
                CTL_O.cpu_clk_en = 1'b1;
                CTL_O.adc_en     = 1'b1;
            end
            LPM_STANDBY: begin
                CTL_O.sys_osc_en = 1'b1;
                CTL_O.adc_en     = 1'b1;
            end
            LPM_STOP: begin
                CTL_O.sub_osc_en = ~ctrl_ff[CTRL_SUBOSC_STP];
                CTL_O.periph_rst = 1'b1;
                CTL_O.port_hiz   = 1'b1;
            end
            LPM_WATCH: begin
                CTL_O.tmr_a_only = 1'b1;
            end
            LPM_SUBACT: begin
                CTL_O.cpu_clk_en = 1'b1;
            end
            LPM_SETTLE: begin
                CTL_O.sys_osc_en = 1'b1;
                CTL_O.periph_rst = was_stop_ff;
                CTL_O.port_hiz   = was_stop_ff;
            end
            default: CTL_O.sys_osc_en = 1'b1;
        endcase
    end

    assign MODE_O        = mode_ff;
    assign RESTART_O     = restart_ff;
    assign RESUME_O      = resume_ff;
    assign EXT_INTERRUPT_ZERO_REQ_O    = ext_interrupt_zero_req_ff;
    assign STROBE_O      = strobe_ff;
    assign RAM_EN_FLAG_O = ram_en_ff;

    //----------------------------------------------------------------
    // Assertions
    //----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);

    AST_STANDBY_ENTRY: assert property (
        mode_ff == LPM_ACTIVE && STANDBY_INSTR_I && !nop_inh
        |=> mode_ff == LPM_STANDBY && CTL_O.sys_osc_en && !CTL_O.cpu_clk_en)
        else $error("standby not entered");
    AST_STANDBY_WAKE: assert property (
        mode_ff == LPM_STANDBY && INT_PEND_I
        |=> mode_ff == LPM_ACTIVE && resume_ff)
        else $error("standby wake failed");
    AST_STOP_ENTRY: assert property (
        mode_ff == LPM_ACTIVE && HALT_INSTR_I && !STANDBY_INSTR_I &&
        !nop_inh && !ctrl_ff[CTRL_WATCH_SEL] |=> mode_ff == LPM_STOP)
        else $error("stop not entered");
    AST_SUBOSC: assert property (
        mode_ff == LPM_STOP |-> CTL_O.sub_osc_en != ctrl_ff[CTRL_SUBOSC_STP])
        else $error("sub oscillator wrong in stop");
    AST_WATCH_ENTRY: assert property (
        mode_ff == LPM_ACTIVE && HALT_INSTR_I && !STANDBY_INSTR_I &&
        !nop_inh && ctrl_ff[CTRL_WATCH_SEL] |=> mode_ff == LPM_WATCH)
        else $error("watch not entered");
    AST_WATCH_SUB: assert property (
        mode_ff == LPM_WATCH && wake_w && ctrl_ff[CTRL_LOW_SPEED]
        |=> mode_ff == LPM_SUBACT)
        else $error("watch to subactive failed");
    AST_DIRECT_CLR: assert property (
        mode_ff == LPM_ACTIVE |=> !ctrl_ff[CTRL_DIRECT])
        else $error("direct flag set in active");
    AST_NOP: assert property (
        mode_ff == LPM_ACTIVE && nop_inh |=> mode_ff == LPM_ACTIVE)
        else $error("low power instr not a no-op");
    AST_STOP_PORTS: assert property (
        mode_ff == LPM_STOP |-> CTL_O.port_hiz && !CTL_O.in_en &&
        CTL_O.periph_rst)
        else $error("stop ports wrong");
    AST_RAM_FLAG: assert property (
        mode_ff == LPM_STOP && stop_cancel_pin_act |=> ram_en_ff &&
        mode_ff == LPM_SETTLE)
        else $error("ram flag not set");
    AST_EDGE_DELAY: assert property (
        strobe_ff && low_pwr && ext_interrupt_zero_smp_ff && !ext_interrupt_zero_lvl && !ext_interrupt_zero_edge_ff
        |=> !ext_interrupt_zero_req_ff)
        else $error("ext_interrupt_zero not deferred");

    COV_STANDBY: cover property (mode_ff == LPM_STANDBY ##1
                                 mode_ff == LPM_ACTIVE);
    COV_STOP_CANCEL_PIN:   cover property (restart_ff);
    COV_SUBACT:  cover property (mode_ff == LPM_SUBACT);
    COV_EXT_INTERRUPT_ZERO:    cover property (ext_interrupt_zero_req_ff && mode_ff == LPM_WATCH);

endmodule : lpm_ctrl

/* src/lpm_pkg.sv */
// Package for the low-power mode controller: mode enum, carriers,
// register map and timing constants.
// Assumes a 25 MHz core clock and a 32-bit APB register port.
package lpm_pkg;

    //----------------------------------------------------------------
    // Register map (byte offsets)
    //----------------------------------------------------------------
    localparam logic [7:0] LPM_CTRL_OFS   = 8'h00; // Control bits
    localparam logic [7:0] LPM_STAT_OFS   = 8'h04; // Mode and flags
    localparam logic [7:0] LPM_FRAME_OFS  = 8'h08; // Frame selection

    // Control register fields
    localparam int CTRL_WATCH_SEL  = 0; // Halt goes to watch when 1
    localparam int CTRL_SUBOSC_STP = 1; // Sub oscillator stops in stop
    localparam int CTRL_SUB_SPEED  = 2; // Subactive speed select
    localparam int CTRL_LOW_SPEED  = 3; // Wake into subactive
    localparam int CTRL_DIRECT     = 4; // Direct transfer to active

    // Reset values
    localparam logic [4:0] CTRL_RST  = 5'h00;
    localparam logic [1:0] FRAME_RST = 2'h0;

    //----------------------------------------------------------------
    // Timing
    //----------------------------------------------------------------
    localparam int CLK_MHZ         = 25;   // Core clock rate
    localparam int SETTLE_US       = 8000; // Oscillator settle period
    localparam int SETTLE_CYC      = SETTLE_US * CLK_MHZ;
    localparam int FRAME0_CYC      = 64;   // Frame lengths in cycles
    localparam int FRAME1_CYC      = 128;
    localparam int FRAME2_CYC      = 256;

    //----------------------------------------------------------------
    // Types
    //----------------------------------------------------------------
    typedef enum logic [2:0] {
        LPM_ACTIVE,
        LPM_STANDBY,
        LPM_STOP,
        LPM_WATCH,
        LPM_SUBACT,
        LPM_SETTLE
    } lpm_mode_t;

    typedef struct packed {
        logic sys_osc_en;   // System oscillator runs
        logic sub_osc_en;   // Subsystem oscillator runs
        logic cpu_clk_en;   // Instruction clocks run
        logic periph_rst;   // Timers, serial, A/D, I/O reset
        logic tmr_a_only;   // Only timer A runs
        logic adc_en;       // A/D allowed
        logic port_hiz;     // Ports high impedance
        logic in_en;        // Port inputs enabled
    } lpm_ctl_t;

endpackage : lpm_pkg
